// >>> shared/mdc_defs.svh
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH
`define MDC_DATA_W        10
`define MDC_ADDR_W        6
`define MDC_CHANNELS      64
`define MDC_BASE_CHANNELS 24
`define MDC_IOT_W         12
`define MDC_CODE_CLEAR    12'o6551
`define MDC_CODE_LOADSEL  12'o6552
`define MDC_CODE_LOADWORD 12'o6562
`define MDC_CODE_UPDATE   12'o6564
`define MDC_EXEC_NS       2600
`define MDC_CLK_NS        5
`define MDC_EXEC_CYC      (`MDC_EXEC_NS / `MDC_CLK_NS)
`endif

// >>> shared/mdc_pkg.sv
package mdc_pkg;
  typedef enum logic [2:0] {
    MDC_OP_NONE,
    MDC_OP_CLEAR,
    MDC_OP_LOADSEL,
    MDC_OP_LOADWORD,
    MDC_OP_UPDATE
  } mdc_op_t;
endpackage : mdc_pkg

// >>> design/mdc_chan_mem.sv
`timescale 1ns/10ps
`include "mdc_defs.svh"
// per-channel staged and output words, registered read
module mdc_chan_mem
  import mdc_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     wr_en,
  input  wire logic [`MDC_ADDR_W-1:0]   wr_addr,
  input  wire logic [`MDC_DATA_W-1:0]   wr_data,
  input  wire logic                     update,
  input  wire logic [`MDC_CHANNELS-1:0] dbl_buf,
  input  wire logic [`MDC_ADDR_W-1:0]   rd_addr,
  output logic      [`MDC_DATA_W-1:0]   rd_data_q
);
  logic [`MDC_DATA_W-1:0] stage_q [`MDC_CHANNELS];
  logic [`MDC_DATA_W-1:0] out_q   [`MDC_CHANNELS];

  // input registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `MDC_CHANNELS; i++) stage_q[i] <= '0;
    end else if (wr_en) begin
      stage_q[wr_addr] <= wr_data;
    end
  end

  // output stage: single-buffered follows load, double waits update
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `MDC_CHANNELS; i++) out_q[i] <= '0;
    end else begin
      for (int i = 0; i < `MDC_CHANNELS; i++) begin
        if (dbl_buf[i]) begin
          if (update) out_q[i] <= stage_q[i];
        end else if (wr_en && wr_addr == i[`MDC_ADDR_W-1:0]) begin
          out_q[i] <= wr_data;
        end
      end
    end
  end

  // registered readout
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rd_data_q <= '0;
    else        rd_data_q <= out_q[rd_addr];
  end
endmodule : mdc_chan_mem

// >>> design/mdc_ctrl.sv
`timescale 1ns/10ps
`include "mdc_defs.svh"
// channel controller: decodes transfer instructions
module mdc_ctrl
  import mdc_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     iot_valid,
  input  wire logic [`MDC_IOT_W-1:0]    iot_code,
  input  wire logic [`MDC_IOT_W-1:0]    cpu_working_register,
  input  wire logic                     expansion_fitted,
  input  wire logic [`MDC_CHANNELS-1:0] dbl_buf,
  input  wire logic [`MDC_ADDR_W-1:0]   mon_addr,
  output logic      [`MDC_ADDR_W-1:0]   chan_lamps_q,
  output logic                          iot_done_q,
  output logic                          iot_ack_q,
  output logic      [`MDC_DATA_W-1:0]   mon_data_q
);
  logic [`MDC_ADDR_W-1:0] chan_sel_q;
  logic                   busy_q;
  mdc_op_t                op;
  logic                   wr_en;
  logic                   upd;
  logic                   in_range;
  logic                     exp_meta_q;
  logic                     exp_sync_q;
  logic [`MDC_CHANNELS-1:0] dbl_meta_q;
  logic [`MDC_CHANNELS-1:0] dbl_sync_q;

  // strap pins cross in through two flops; only the second is read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      exp_meta_q <= 1'b0;
      exp_sync_q <= 1'b0;
      dbl_meta_q <= '0;
      dbl_sync_q <= '0;
    end else begin
      exp_meta_q <= expansion_fitted;
      exp_sync_q <= exp_meta_q;
      dbl_meta_q <= dbl_buf;
      dbl_sync_q <= dbl_meta_q;
    end
  end

  // opcode decode; other codes ignored
  function automatic mdc_op_t decode(input logic [`MDC_IOT_W-1:0] c);
    if (c == `MDC_CODE_CLEAR)         return MDC_OP_CLEAR;
    else if (c == `MDC_CODE_LOADSEL)  return MDC_OP_LOADSEL;
    else if (c == `MDC_CODE_LOADWORD) return MDC_OP_LOADWORD;
    else if (c == `MDC_CODE_UPDATE)   return MDC_OP_UPDATE;
    else                              return MDC_OP_NONE;
  endfunction : decode

  // fitted channels: 24 base, 64 with expansion
  assign in_range = exp_sync_q ||
                    (chan_sel_q < `MDC_ADDR_W'(`MDC_BASE_CHANNELS));
  assign op    = (iot_valid && !busy_q) ? decode(iot_code) : MDC_OP_NONE;
  assign wr_en = (op == MDC_OP_LOADWORD) && in_range;
  assign upd   = (op == MDC_OP_UPDATE);

  // channel-select register, held until cleared or loaded
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) chan_sel_q <= '0;
    else if (op == MDC_OP_CLEAR) chan_sel_q <= '0;
    else if (op == MDC_OP_LOADSEL)
      chan_sel_q <= cpu_working_register[`MDC_ADDR_W-1:0];
  end

  // front-panel indicators
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) chan_lamps_q <= '0;
    else        chan_lamps_q <= (op == MDC_OP_CLEAR) ? '0 :
                 (op == MDC_OP_LOADSEL) ? cpu_working_register[`MDC_ADDR_W-1:0] : chan_sel_q;
  end

  // one-cycle completion, well inside execution time
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      iot_done_q <= 1'b0;
      iot_ack_q  <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      iot_done_q <= (op != MDC_OP_NONE);
      iot_ack_q  <= (op != MDC_OP_NONE);
      busy_q     <= (op != MDC_OP_NONE);
    end
  end

  mdc_chan_mem u_mem (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .wr_en     (wr_en),
    .wr_addr   (chan_sel_q),
    .wr_data   (cpu_working_register[`MDC_DATA_W-1:0]),
    .update    (upd),
    .dbl_buf   (dbl_sync_q),
    .rd_addr   (mon_addr),
    .rd_data_q (mon_data_q)
  );
endmodule : mdc_ctrl

// >>> tb/mdc_checker.sv
`timescale 1ns/10ps
`include "mdc_defs.svh"
module mdc_checker(input wire logic mclk, rst_b, iot_valid, iot_done_q, iot_ack_q,
  input wire logic [11:0] iot_code, cpu_working_register, input wire logic [5:0] chan_lamps_q);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // decode of the four answered codes
  wire logic cl = iot_code == `MDC_CODE_CLEAR, ld = iot_code == `MDC_CODE_LOADSEL;
  wire logic kn = cl | ld | iot_code == `MDC_CODE_LOADWORD | iot_code == `MDC_CODE_UPDATE;
  wire logic tk = iot_valid & kn & !iot_done_q;
  a_clr_zero: assert property (tk & cl |=> chan_lamps_q == 6'h0) else $error("clear");
  a_sel_load: assert property (tk & ld |=> chan_lamps_q == $past(cpu_working_register[5:0])) else $error("sel");
  a_sel_hold: assert property (!(tk & (cl | ld)) |=> $stable(chan_lamps_q)) else $error("hold");
  a_done_next: assert property (tk |=> iot_done_q) else $error("no done");
  a_done_cause: assert property (iot_done_q |-> $past(tk)) else $error("stray");
  a_done_one: assert property (iot_done_q |=> !iot_done_q) else $error("long");
  a_ack_done: assert property (iot_ack_q == iot_done_q) else $error("ack");
  a_odd_quiet: assert property (iot_valid & !kn |=> !iot_done_q) else $error("odd");
  c_clr: cover property (tk & cl);
  c_sel: cover property (tk & ld);
  c_upd: cover property (tk & iot_code == `MDC_CODE_UPDATE);
  c_word: cover property (tk & iot_code == `MDC_CODE_LOADWORD);
endmodule : mdc_checker
bind mdc_ctrl mdc_checker u_chk(.mclk, .rst_b, .iot_valid, .iot_done_q, .iot_ack_q, .iot_code,
  .cpu_working_register, .chan_lamps_q);

// >>> tb/mdc_host.sv
`timescale 1ns/10ps
module mdc_host(
  input  wire logic        mclk,
  input  wire logic        iot_done_q,
  input  wire logic        iot_ack_q,
  output logic             iot_valid,
  output logic      [11:0] iot_code,
  output logic      [11:0] cpu_working_register
);
  initial begin
    iot_valid = 0;
    iot_code = 0;
    cpu_working_register = 0;
  end
  // one transfer per call, released lines inverted
  task automatic issue(input logic [11:0] c, w, output logic d, k);
    @(posedge mclk);
    #1 {iot_valid, iot_code, cpu_working_register} = {1'b1, c, w};
    @(posedge mclk);
    #1 {iot_valid, iot_code, cpu_working_register} = {1'b0, ~c, ~w};
    d = iot_done_q;
    k = iot_ack_q;
    @(posedge mclk);
    #1;
  endtask : issue
endmodule : mdc_host

// >>> tb/tb.sv
`timescale 1ns/10ps
`include "mdc_defs.svh"
module tb;
  logic mclk = 0, rst_b = 0, ex = 0, d, k, v, dn, ak;
  logic [11:0] c, w, cd[4] = '{`MDC_CODE_CLEAR, `MDC_CODE_LOADSEL, `MDC_CODE_LOADWORD, `MDC_CODE_UPDATE};
  logic [63:0] db = 0;
  logic [5:0] mo = 0, lp, a = 0;
  logic [9:0] md;
  int err_total, checks_done, st[64], ov[64];
  always #2.5 mclk = ~mclk;
  mdc_host host(.mclk, .iot_done_q(dn), .iot_ack_q(ak), .iot_valid(v), .iot_code(c), .cpu_working_register(w));
  mdc_ctrl dut(.mclk, .rst_b, .iot_valid(v), .iot_code(c), .cpu_working_register(w), .expansion_fitted(ex),
    .dbl_buf(db), .mon_addr(mo), .chan_lamps_q(lp), .iot_done_q(dn), .iot_ack_q(ak), .mon_data_q(md));
  task automatic chk(input logic [11:0] g, e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask : chk
  // one instruction plus model update
  task automatic op(input logic [11:0] x, y);
    host.issue(x, y, d, k);
    chk({11'h0, d}, 12'h1);
    chk({11'h0, k}, 12'h1);
    case (x)
      `MDC_CODE_CLEAR: a = 0;
      `MDC_CODE_LOADSEL: a = y[5:0];
      `MDC_CODE_LOADWORD: if (a < `MDC_BASE_CHANNELS || ex) begin
        st[a] = y[9:0];
        if (!db[a]) ov[a] = st[a];
      end
      default: for (int i = 0; i < 64; i++) if (db[i]) ov[i] = st[i];
    endcase
    chk({6'h0, lp}, {6'h0, a});
  endtask : op
  task automatic rd(input logic [5:0] ch);
    @(posedge mclk);
    #1 mo = ch;
    @(posedge mclk);
    #1 chk({2'h0, md}, 12'(ov[ch]));
  endtask : rd
  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'hfe5abeea));
    db = {$urandom, $urandom};
    repeat (20) @(posedge mclk);
    #1 rst_b = 1;
    rd(6'h0);
    for (int n = 0; n < 400; n++) begin
      if (n == 201) begin
        ex = 1;
        repeat (3) @(posedge mclk);
      end
      op(cd[$urandom % 4], 12'($urandom));
      rd(6'($urandom));
      host.issue(12'o6553 + 12'(n % 2), 12'($urandom), d, k);
      chk({11'h0, d}, 12'h0);
      chk({11'h0, k}, 12'h0);
    end
    op(cd[3], 12'h0);
    for (int i = 0; i < 64; i++) rd(6'(i));
    tally_and_finish();
  end
  // hang guard
  initial begin
    #50us err_total++;
    tally_and_finish();
  end
endmodule : tb
